/* File: common/urm_pkg.sv */
// shared constants for the uart register map and fifo control block
package urm_pkg;
	// ***************************
	// register offsets
	// ***************************
	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_IRQ_ENABLE = 3'h1;
	localparam logic [2:0] OFS_IDENT_FIFO = 3'h2;
	localparam logic [2:0] OFS_LINE_CONTROL = 3'h3;
	localparam logic [2:0] OFS_MODEM_CONTROL = 3'h4;
	localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
	localparam logic [2:0] OFS_MODEM_STATUS = 3'h6;
	localparam logic [2:0] OFS_SCRATCH = 3'h7;
	// ***************************
	// field positions
	// ***************************
	localparam int FC_ENABLE = 0;
	localparam int FC_RX_FLUSH = 1;
	localparam int FC_TX_FLUSH = 2;
	localparam int FC_MODE = 3;
	localparam int FC_TRIG_LO = 6;
	localparam int FC_TRIG_HI = 7;
	localparam int LC_DIV_ACCESS = 7;
	localparam int IE_RX_DATA = 0;
	localparam int IE_TX_EMPTY = 1;
	localparam int IE_USED_MSB = 3;
	localparam int MC_USED_MSB = 5;
	localparam int ID_TIMEOUT = 3;
	localparam int LS_DATA_READY = 0;
	localparam int LS_THR_EMPTY = 5;
	localparam int LS_TX_EMPTY = 6;
	localparam int LS_FIFO_ERR = 7;
	// ***************************
	// reset values and codes
	// ***************************
	localparam logic [7:0] RESET_ZERO = 8'h00;
	localparam logic [7:0] ID_NONE = 8'h01;
	localparam logic [7:0] ID_RX_DATA = 8'h04;
	localparam logic [7:0] ID_TX_EMPTY = 8'h02;
	localparam logic [1:0] ID_FIFOS_ON = 2'h3;
	localparam logic [4:0] TRIG_1 = 5'h01;
	localparam logic [4:0] TRIG_4 = 5'h04;
	localparam logic [4:0] TRIG_8 = 5'h08;
	localparam logic [4:0] TRIG_14 = 5'h0e;
	localparam int FIFO_DEPTH = 16;
	localparam int STAGE_DEPTH = 2;
endpackage

/* File: verification/urm_regs_props.sv */
// concurrent checks on the ports of the register map block
`timescale 1ns/1ps
`default_nettype none
module urm_regs_props
	import urm_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [2:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	input wire logic rx_valid,
	input wire logic rx_timeout,
	input wire logic [7:0] line_control_out,
	input wire logic [15:0] divisor_out,
	input wire logic receive_ready_out,
	input wire logic tx_empty_irq
);
	// ****
	// shadow of the enable bits
	// ****
	logic fen;
	logic ie_tx;
	logic dl;
	assign dl = line_control_out[LC_DIV_ACCESS];
	always_ff @(posedge mclk)
	begin
		if (srst)
			fen <= 1'b0;
		else if (wr_en && addr == OFS_IDENT_FIFO)
			fen <= wr_data[FC_ENABLE];
	end
	always_ff @(posedge mclk)
	begin
		if (srst)
			ie_tx <= 1'b0;
		else if (wr_en && addr == OFS_IRQ_ENABLE && !dl)
			ie_tx <= wr_data[IE_TX_EMPTY];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// ****
	// properties
	// ****
	property p_ident_on;
		rd_en && addr == OFS_IDENT_FIFO && fen |=> rd_data[7:4] == {ID_FIFOS_ON, 2'h0};
	endproperty
	a_ident_on: assert property (p_ident_on) else $error("ident fifo bits wrong");
	property p_ident_off;
		rd_en && addr == OFS_IDENT_FIFO && !fen |=> rd_data[7:6] == 2'h0 && !rd_data[ID_TIMEOUT];
	endproperty
	a_ident_off: assert property (p_ident_off) else $error("ident bits not zero");
	property p_ie_read;
		rd_en && addr == OFS_IRQ_ENABLE && !dl |=> rd_data[7:4] == 4'h0;
	endproperty
	a_ie_read: assert property (p_ie_read) else $error("irq enable high bits set");
	property p_tx_irq;
		!ie_tx |-> !tx_empty_irq;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("tx irq while disabled");
	property p_div_lo;
		wr_en && addr == OFS_DATA && dl |=> divisor_out[7:0] == $past(wr_data);
	endproperty
	a_div_lo: assert property (p_div_lo) else $error("divisor low not loaded");
	property p_div_hi;
		wr_en && addr == OFS_IRQ_ENABLE && dl |=> divisor_out[15:8] == $past(wr_data);
	endproperty
	a_div_hi: assert property (p_div_hi) else $error("divisor high not loaded");
	// the flush drops a byte arriving in the same cycle; such cycles are excluded all the same
	property p_rx_flush;
		wr_en && addr == OFS_IDENT_FIFO && wr_data[1:0] == 2'h3 && !rx_valid && !rx_timeout
			|=> !receive_ready_out;
	endproperty
	a_rx_flush: assert property (p_rx_flush) else $error("rx flush left data");
	property p_en_change;
		wr_en && addr == OFS_IDENT_FIFO && wr_data[0] != fen && !rx_valid && !rx_timeout
			|=> !receive_ready_out;
	endproperty
	a_en_change: assert property (p_en_change) else $error("enable change kept data");
	c_fifo_ready: cover property (fen && receive_ready_out);
	c_div: cover property (wr_en && dl);
	c_irq: cover property (tx_empty_irq);
endmodule // urm_regs_props
bind urm_regs urm_regs_props i_props(.mclk, .srst, .addr, .wr_en, .rd_en, .wr_data,
	.rd_data, .rx_valid, .rx_timeout, .line_control_out, .divisor_out,
	.receive_ready_out, .tx_empty_irq);
`default_nettype wire

/* File: verification/urm_regs_tb_top.sv */
// testbench for the register map and fifo control block
`timescale 1ns/1ps
`default_nettype none
module urm_regs_tb_top;
	import urm_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] rd_data;
	logic rx_valid;
	logic rx_ready;
	logic [7:0] rx_data;
	logic tx_valid;
	logic tx_ready;
	logic [7:0] tx_data;
	logic stall = 1'b0;
	logic rx_error = 1'b0;
	logic rx_timeout = 1'b0;
	logic tx_busy = 1'b0;
	logic tx_rdy;
	logic rx_irq;
	logic [5:0] mc;
	logic [7:0] lc;
	logic [15:0] dv;
	logic rr;
	logic tx_irq;
	logic [7:0] v;
	int errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int lvl[4] = '{1, 4, 8, 14};
	always #2 mclk = ~mclk;
	urm_regs i_urm_regs(.mclk(mclk), .srst(srst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
		.wr_data(wr_data), .rd_data(rd_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_data(rx_data), .rx_error(rx_error), .rx_timeout(rx_timeout), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_shift_busy(tx_busy), .modem_inputs(4'ha),
		.line_control_out(lc), .divisor_out(dv), .modem_control_out(mc), .receive_ready_out(rr),
		.transmit_ready_out(tx_rdy), .rx_data_irq(rx_irq), .tx_empty_irq(tx_irq));
	urm_shifter_model i_urm_shifter_model(.mclk(mclk), .srst(srst), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data), .stall(stall));
	// ****
	// bus tasks
	// ****
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge mclk);
		addr = a;
		wr_data = d;
		wr_en = 1'b1;
		@(negedge mclk);
		wr_en = 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(negedge mclk);
		addr = a;
		rd_en = 1'b1;
		@(negedge mclk);
		rd_en = 1'b0;
		v = rd_data;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// a hang ends the run as a failure
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			wrap_up;
		end
	end
	// ****
	// tests
	// ****
	initial
	begin
		repeat (10) @(negedge mclk);
		srst = 1'b0;
		rd(OFS_IDENT_FIFO); chk(v, ID_NONE);
		rd(OFS_IRQ_ENABLE); chk(v, RESET_ZERO);
		wr(OFS_IDENT_FIFO, 8'hc3);
		i_urm_shifter_model.send(8'ha5);
		chk(rr, 1'b1);
		rd(OFS_IDENT_FIFO); chk(v, 8'hc1);
		rd(OFS_DATA); chk(v, 8'ha5);
		for (int k = 0; k < 4; k++)
		begin
			wr(OFS_IDENT_FIFO, {k[1:0], 6'h0b});
			repeat (lvl[k] - 1) i_urm_shifter_model.send(8'h40 + k[7:0]);
			chk(rr, 1'b0);
			i_urm_shifter_model.send(8'h50);
			chk(rr, 1'b1);
			wr(OFS_IDENT_FIFO, {k[1:0], 6'h0b});
			chk(rr, 1'b0);
		end
		wr(OFS_IDENT_FIFO, 8'h07);
		wr(OFS_DATA, 8'h3c);
		repeat (10) @(negedge mclk);
		chk(i_urm_shifter_model.got.size(), 16'h1);
		chk(i_urm_shifter_model.got[0], 8'h3c);
		stall = 1'b1;
		for (int i = 1; i < 6; i++)
			wr(OFS_DATA, 8'h10 * i[7:0]);
		chk(tx_rdy, 1'b0);
		wr(OFS_IDENT_FIFO, 8'h05);
		rd(OFS_LINE_STATUS); chk(v[LS_THR_EMPTY], 1'b1);
		chk(tx_rdy, 1'b1);
		stall = 1'b0;
		repeat (20) @(negedge mclk);
		chk(i_urm_shifter_model.got.size(), 16'h1);
		tx_busy = 1'b1;
		rd(OFS_LINE_STATUS); chk(v[LS_TX_EMPTY], 1'b0);
		tx_busy = 1'b0;
		rd(OFS_LINE_STATUS); chk(v[LS_TX_EMPTY], 1'b1);
		wr(OFS_IRQ_ENABLE, 8'hff);
		rd(OFS_IRQ_ENABLE); chk(v, 8'h0f);
		chk(tx_irq, 1'b1);
		rd(OFS_IDENT_FIFO); chk(v, 8'hc2);
		chk(tx_irq, 1'b0);
		repeat (4) @(negedge mclk);
		chk(tx_irq, 1'b0);
		rx_timeout = 1'b1;
		rd(OFS_IDENT_FIFO); chk(v, 8'hcc);
		chk(rx_irq, 1'b1);
		rx_timeout = 1'b0;
		rx_error = 1'b1;
		@(negedge mclk);
		rx_error = 1'b0;
		rd(OFS_LINE_STATUS); chk(v[LS_FIFO_ERR], 1'b1);
		rd(OFS_LINE_STATUS); chk(v[LS_FIFO_ERR], 1'b0);
		wr(OFS_IRQ_ENABLE, 8'h00);
		i_urm_shifter_model.send(8'h5a);
		wr(OFS_IDENT_FIFO, 8'h00);
		rx_error = 1'b1;
		@(negedge mclk);
		rx_error = 1'b0;
		rd(OFS_LINE_STATUS); chk(v[LS_DATA_READY], 1'b0);
		chk(v[LS_FIFO_ERR], 1'b0);
		rd(OFS_IDENT_FIFO); chk(v & 8'hc8, 8'h00);
		wr(OFS_IDENT_FIFO, 8'hc8);
		i_urm_shifter_model.send(8'h77);
		chk(rr, 1'b1);
		rd(OFS_IDENT_FIFO); chk(v & 8'hc0, 8'h00);
		wr(OFS_IRQ_ENABLE, 8'h01);
		rx_timeout = 1'b1;
		rd(OFS_IDENT_FIFO); chk(v, 8'h04);
		chk(rx_irq, 1'b1);
		rx_timeout = 1'b0;
		wr(OFS_MODEM_CONTROL, 8'hff);
		chk(mc, 16'h3f);
		rd(OFS_MODEM_STATUS); chk(v, 8'ha0);
		wr(OFS_LINE_CONTROL, 8'h80);
		wr(OFS_DATA, 8'h34);
		wr(OFS_IRQ_ENABLE, 8'h12);
		chk(dv, 16'h1234);
		rd(OFS_DATA); chk(v, 8'h34);
		wr(OFS_LINE_CONTROL, 8'h03);
		chk(lc, 8'h03);
		wrap_up;
	end
endmodule // urm_regs_tb_top
`default_nettype wire

/* File: verification/urm_shifter_model.sv */
// model of the serial shifters beside the register map
`timescale 1ns/1ps
`default_nettype none
module urm_shifter_model
(
	input wire logic mclk,
	input wire logic srst,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic stall
);
	logic [7:0] got[$];
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end
	assign tx_ready = !stall && !srst;
	// bit 0 of each byte is the first serial bit
	always @(posedge mclk)
	begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
	end
	// data line shows the inverse once released so stale bytes cannot pass
	task automatic send(input logic [7:0] b);
		@(negedge mclk);
		rx_valid = 1'b1;
		rx_data = b;
		while (!rx_ready)
			@(negedge mclk);
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_data = ~b;
	endtask
endmodule // urm_shifter_model
`default_nettype wire

/* File: verilog/urm_fifo.sv */
// byte fifo with flush, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module urm_fifo
	import urm_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = FIFO_DEPTH,
	parameter int AW = $clog2(DEPTH)
)(
	input wire logic mclk,
	input wire logic srst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [AW:0] count
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic push;
	logic pop;

	// full at DEPTH words; the count is one bit wider than the pointers
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge mclk)
		if (push)
		begin
			mem[wr_ptr] <= in_data;
		end

	// a flush drops stored words but leaves the shifter outside untouched
	always_ff @(posedge mclk)
		if (srst || flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop)
			begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
endmodule // urm_fifo
`default_nettype wire

/* File: verilog/urm_regs.sv */
// host register map with fifo control for one serial channel
// How it works
// - offset 2 writes fifo_control, reads interrupt_ident.
// - fifo_control bit 0 enables the receive fifo; clear means character buffer mode. The transmit fifo is always in use.
// - writes with bit 0 clear ignore other fifo_control bits; host sets bit 0.
// - any write changing the enable bit empties both fifos.
// - bit 1 flushes receive fifo and its count, self-clearing.
// - bit 2 flushes transmit fifo and its count, self-clearing.
// - with fifos enabled, bit 3 selects mode 1 ready signalling.
// - bits 4 and 5 are reserved and do nothing.
// - bits 7:6 set receive trigger: 1, 4, 8 or 14 bytes.
// - data bit 0 is the first serial bit, lsb first.
// - in character mode timeout, fifos-enabled and fifo error bits read zero.
// - offset 0 write loads transmit_holding, read returns receive_buffer.
// - interrupt_enable bit 1 enables tx empty interrupt; bits 7:4 read zero.
// - line_control bit 7 maps offsets 0 and 1 to the divisor bytes.
// - fifos-enabled bits read one while the enable bit is set.
`timescale 1ns/1ps
`default_nettype none
module urm_regs
	import urm_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [2:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_error,
	input wire logic rx_timeout,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	input wire logic tx_shift_busy,
	input wire logic [3:0] modem_inputs,
	output logic [7:0] line_control_out,
	output logic [15:0] divisor_out,
	output logic [5:0] modem_control_out,
	output logic receive_ready_out,
	output logic transmit_ready_out,
	output logic rx_data_irq,
	output logic tx_empty_irq
);
	// ***************************
	// registers
	// ***************************
	logic [7:0] fifo_control;
	logic [3:0] interrupt_enable;
	logic [7:0] line_control;
	logic [5:0] modem_control;
	logic [7:0] scratch_pad;
	logic [7:0] divisor_low_byte;
	logic [7:0] divisor_high_byte;
	logic [7:0] receive_buffer;
	logic rx_buf_full;
	logic rx_err_seen;
	logic thr_irq_armed;
	logic [7:0] ident_value;
	logic fifo_enable_bit;
	logic ready_signal_mode_bit;
	logic divisor_access_select;
	logic rx_flush;
	logic tx_flush;
	logic [4:0] trigger_level;
	logic [$clog2(DEPTH):0] rx_count;
	logic [$clog2(DEPTH):0] tx_count;
	logic rxf_valid;
	logic rxf_ready;
	logic [7:0] rxf_data;
	logic txf_in_ready;
	logic txf_out_valid;
	logic txf_out_ready;
	logic [7:0] txf_out_data;
	logic wr_ctrl;
	logic wr_data_reg;
	logic rd_data_reg;
	logic rd_ident;
	logic rx_ready_fifo;
	logic tx_was_empty;

	assign fifo_enable_bit = fifo_control[FC_ENABLE];
	assign ready_signal_mode_bit = fifo_control[FC_MODE] && fifo_enable_bit;
	assign divisor_access_select = line_control[LC_DIV_ACCESS];
	assign wr_ctrl = wr_en && addr == OFS_IDENT_FIFO;
	assign wr_data_reg = wr_en && addr == OFS_DATA && !divisor_access_select;
	assign rd_data_reg = rd_en && addr == OFS_DATA && !divisor_access_select;
	assign rd_ident = rd_en && addr == OFS_IDENT_FIFO;

	// ***************************
	// fifo control write
	// ***************************
	// enable change flushes both; explicit flush only counts when bit 0 set
	assign rx_flush = wr_ctrl && ((wr_data[FC_ENABLE] != fifo_enable_bit)
		|| (wr_data[FC_ENABLE] && wr_data[FC_RX_FLUSH]));
	assign tx_flush = wr_ctrl && ((wr_data[FC_ENABLE] != fifo_enable_bit)
		|| (wr_data[FC_ENABLE] && wr_data[FC_TX_FLUSH]));

	// flush bits are never stored, so they read back as self-cleared
	always_ff @(posedge mclk)
		if (srst)
		begin
			fifo_control <= RESET_ZERO;
		end
		else if (wr_ctrl)
		begin
			if (wr_data[FC_ENABLE])
			begin
				fifo_control <= {wr_data[FC_TRIG_HI:FC_TRIG_LO], 2'h0, wr_data[FC_MODE], 2'h0,
					1'b1};
			end
			else
			begin
				fifo_control <= RESET_ZERO;
			end
		end

	always_comb
		unique case (fifo_control[FC_TRIG_HI:FC_TRIG_LO])
			2'h0: trigger_level = TRIG_1;
			2'h1: trigger_level = TRIG_4;
			2'h2: trigger_level = TRIG_8;
			2'h3: trigger_level = TRIG_14;
		endcase

	// ***************************
	// other host registers
	// ***************************
	always_ff @(posedge mclk)
		if (srst)
		begin
			interrupt_enable <= 4'h0;
			line_control <= RESET_ZERO;
			modem_control <= 6'h00;
		end
		else if (wr_en)
		begin
			if (addr == OFS_IRQ_ENABLE && !divisor_access_select)
			begin
				interrupt_enable <= wr_data[IE_USED_MSB:0];
			end
			if (addr == OFS_LINE_CONTROL)
			begin
				line_control <= wr_data;
			end
			if (addr == OFS_MODEM_CONTROL)
			begin
				modem_control <= wr_data[MC_USED_MSB:0];
			end
		end

	// divisor and scratch are not touched by reset
	always_ff @(posedge mclk)
		if (wr_en)
		begin
			if (addr == OFS_DATA && divisor_access_select)
			begin
				divisor_low_byte <= wr_data;
			end
			if (addr == OFS_IRQ_ENABLE && divisor_access_select)
			begin
				divisor_high_byte <= wr_data;
			end
			if (addr == OFS_SCRATCH)
			begin
				scratch_pad <= wr_data;
			end
		end

	// ***************************
	// receive path
	// ***************************
	urm_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rx_fifo (
		.mclk(mclk),
		.srst(srst),
		.flush(rx_flush),
		.in_valid(rx_valid && fifo_enable_bit),
		.in_ready(rx_ready_fifo),
		.in_data(rx_data),
		.out_valid(rxf_valid),
		.out_ready(rxf_ready),
		.out_data(rxf_data),
		.count(rx_count)
	);
	assign rxf_ready = rd_data_reg && fifo_enable_bit;
	// character mode: single holding byte, new byte overwrites (overrun is upstream's)
	assign rx_ready = fifo_enable_bit ? rx_ready_fifo : 1'b1;

	always_ff @(posedge mclk)
		if (srst || rx_flush)
		begin
			rx_buf_full <= 1'b0;
		end
		else if (!fifo_enable_bit)
		begin
			if (rx_valid)
			begin
				rx_buf_full <= 1'b1; // set wins over the read clear
			end
			else if (rd_data_reg)
			begin
				rx_buf_full <= 1'b0;
			end
		end

	always_ff @(posedge mclk)
		if (!fifo_enable_bit && rx_valid)
		begin
			receive_buffer <= rx_data;
		end

	always_ff @(posedge mclk)
		if (srst || rx_flush)
		begin
			rx_err_seen <= 1'b0;
		end
		else if (rx_error)
		begin
			rx_err_seen <= 1'b1;
		end
		else if (rd_en && addr == OFS_LINE_STATUS)
		begin
			rx_err_seen <= 1'b0;
		end

	// ***************************
	// transmit path
	// ***************************
	urm_fifo #(.WIDTH(8), .DEPTH(DEPTH)) tx_fifo (
		.mclk(mclk),
		.srst(srst),
		.flush(tx_flush),
		.in_valid(wr_data_reg),
		.in_ready(txf_in_ready),
		.in_data(wr_data),
		.out_valid(txf_out_valid),
		.out_ready(txf_out_ready),
		.out_data(txf_out_data),
		.count(tx_count)
	);
	// the stage decouples a stalled shifter from the host write timing
	urm_skid #(.WIDTH(8)) tx_stage (
		.mclk(mclk),
		.srst(srst),
		.flush(tx_flush),
		.in_valid(txf_out_valid),
		.in_ready(txf_out_ready),
		.in_data(txf_out_data),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);

	// tx empty interrupt arms at reset and on the step into empty only, so an ident read clears it for good
	always_ff @(posedge mclk)
		tx_was_empty <= srst || (tx_count == '0 && !tx_valid);

	always_ff @(posedge mclk)
		if (srst)
		begin
			thr_irq_armed <= 1'b1;
		end
		else if (wr_data_reg || tx_count != '0 || tx_valid)
		begin
			thr_irq_armed <= 1'b0;
		end
		else if (!tx_was_empty)
		begin
			thr_irq_armed <= 1'b1; // set wins over the ident read clear
		end
		else if (rd_ident && ident_value[3:0] == ID_TX_EMPTY[3:0])
		begin
			thr_irq_armed <= 1'b0;
		end

	// ***************************
	// outputs and read mux
	// ***************************
	assign rx_data_irq = interrupt_enable[IE_RX_DATA] && (fifo_enable_bit ?
		({1'b0, rx_count} >= {1'b0, trigger_level}) || rx_timeout : rx_buf_full);
	assign tx_empty_irq = interrupt_enable[IE_TX_EMPTY] && thr_irq_armed;
	// mode 0: ready while any byte / fifo empty; mode 1: trigger / room at all
	assign receive_ready_out = ready_signal_mode_bit ?
		({1'b0, rx_count} >= {1'b0, trigger_level}) || rx_timeout :
		(fifo_enable_bit ? rxf_valid : rx_buf_full);
	assign transmit_ready_out = ready_signal_mode_bit ? txf_in_ready :
		(tx_count == '0 && !tx_valid);
	assign line_control_out = line_control;
	assign divisor_out = {divisor_high_byte, divisor_low_byte};
	assign modem_control_out = modem_control;

	always_comb
	begin
		ident_value = ID_NONE;
		if (rx_data_irq)
		begin
			ident_value = ID_RX_DATA;
			ident_value[ID_TIMEOUT] = fifo_enable_bit && rx_timeout;
		end
		else if (tx_empty_irq)
		begin
			ident_value = ID_TX_EMPTY;
		end
		ident_value[7:6] = fifo_enable_bit ? ID_FIFOS_ON : 2'h0;
	end

	always_ff @(posedge mclk)
		if (srst)
		begin
			rd_data <= RESET_ZERO;
		end
		else if (rd_en)
		begin
			unique case (addr)
				OFS_DATA: rd_data <= divisor_access_select ? divisor_low_byte :
					(fifo_enable_bit ? rxf_data : receive_buffer);
				OFS_IRQ_ENABLE: rd_data <= divisor_access_select ? divisor_high_byte :
					{4'h0, interrupt_enable};
				OFS_IDENT_FIFO: rd_data <= ident_value;
				OFS_LINE_CONTROL: rd_data <= line_control;
				OFS_MODEM_CONTROL: rd_data <= {2'h0, modem_control};
				OFS_LINE_STATUS:
				begin
					rd_data <= RESET_ZERO;
					rd_data[LS_DATA_READY] <= fifo_enable_bit ? rxf_valid : rx_buf_full;
					rd_data[LS_THR_EMPTY] <= (tx_count == '0);
					rd_data[LS_TX_EMPTY] <= (tx_count == '0) && !tx_valid && !tx_shift_busy;
					rd_data[LS_FIFO_ERR] <= fifo_enable_bit && rx_err_seen;
				end
				OFS_MODEM_STATUS: rd_data <= {modem_inputs, 4'h0};
				OFS_SCRATCH: rd_data <= scratch_pad;
			endcase
		end
endmodule // urm_regs
`default_nettype wire

/* File: verilog/urm_skid.sv */
// two-entry buffer so a stalled receiver loses no word
`timescale 1ns/1ps
`default_nettype none
module urm_skid
	import urm_pkg::*;
#(
	parameter int WIDTH = 8
)(
	input wire logic mclk,
	input wire logic srst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] slot [STAGE_DEPTH];
	logic [1:0] fill;
	logic push;
	logic pop;

	assign in_ready = (fill != 2'h2);
	assign out_valid = (fill != 2'h0);
	assign out_data = slot[0];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// slot 0 is always the head; shift on pop
	always_ff @(posedge mclk)
		if (srst || flush)
		begin
			fill <= 2'h0;
		end
		else
		begin
			fill <= fill + 2'(push) - 2'(pop);
		end

	always_ff @(posedge mclk)
	begin
		if (pop)
		begin
			slot[0] <= (fill == 2'h2) ? slot[1] : in_data;
		end
		else if (push && fill == 2'h0)
		begin
			slot[0] <= in_data;
		end
		if (push && ((fill == 2'h1 && !pop) || (fill == 2'h2)))
		begin
			slot[1] <= in_data;
		end
	end
endmodule // urm_skid
`default_nettype wire
